//--- rtl/sdd_decoder.sv
// Top of the shift/deposit operation decoder: registers one decode per claimed slot while enabled,
// and exposes control and statistics through a simple register port.
// Assumes slot_valid and slot_word come from logic on core_clk, and that the
// register master keeps its strobes one cycle long and never both at once.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Claim integer shift group only at opcode 5
// RULE2: Bits 35:34 pick the opcode-5 subgroup
// RULE3: Bit 33 further selects within opcode 5
// RULE4: Bit 13 splits field pull and tests
// RULE5: Bit 26 splits most field inserts
// RULE6: Test, pull and pair-shift encodings mapped
// RULE7: Zero-insert and one-bit insert encodings mapped
// RULE8: Opcode 7 fixed right shifts, count 18:14
// RULE9: Opcode 7 variable left shifts, three sizes
// RULE10: Opcode 7 fixed left shifts, count 24:20
// RULE11: Unassigned opcode 5/7 combinations flagged illegal
module sdd_decoder #(
  parameter int CNT_W = 16 // Width of the statistics counters
) (
  input wire logic core_clk, // Core clock, 200 MHz
  input wire logic rstn, // Synchronous reset, active low
  input wire logic slot_valid, // Slot present this cycle
  input wire logic [40:0] slot_word, // Instruction slot
  input wire logic [3:0] bus_addr, // Register byte address
  input wire logic [31:0] bus_wdata, // Register write data
  input wire logic bus_wr, // Write strobe
  input wire logic bus_rd, // Read strobe
  output logic [31:0] bus_rdata, // Read data, cycle after the read strobe
  output logic dec_valid, // Decode result present
  output sdd_pkg::sdd_op_t dec_op, // Decoded operation
  output sdd_pkg::sdd_size_t dec_size, // Element size of a multimedia op
  output logic [4:0] dec_count, // Immediate shift count
  output logic dec_sub_sel, // Sub-operation selector bit taken
  output logic dec_illegal, // Claimed group but unassigned encoding
  output logic [5:0] dec_guard_pred, // guard_pred field
  output logic [6:0] dec_dst_reg, // Destination register field
  output logic [6:0] dec_src2_reg, // Second source register field
  output logic [6:0] dec_src3_reg // Third source register field
);

  // Combinational decode results
  sdd_pkg::sdd_op_t cmb_op;
  sdd_pkg::sdd_size_t cmb_size;
  logic [4:0] cmb_count;
  logic cmb_sub_sel;
  logic cmb_claimed;
  logic cmb_illegal;

  // Result pipeline registers
  logic valid_q, valid_d;
  sdd_pkg::sdd_op_t op_q, op_d;
  sdd_pkg::sdd_size_t size_q, size_d;
  logic [4:0] count_q, count_d;
  logic sub_sel_q, sub_sel_d;
  logic illegal_q, illegal_d;
  logic [5:0] pred_q, pred_d;
  logic [6:0] dst_q, dst_d;
  logic [6:0] src2_q, src2_d;
  logic [6:0] src3_q, src3_d;

  // Software-visible state
  logic enable_q, enable_d; // Decode enable from the control register
  logic [CNT_W-1:0] ill_cnt_q, ill_cnt_d; // Illegal encodings seen
  logic [CNT_W-1:0] dec_cnt_q, dec_cnt_d; // Slots claimed by this decoder
  sdd_pkg::sdd_op_t last_op_q, last_op_d; // Last claimed operation
  logic [31:0] rdata_q, rdata_d; // Read data holding register

  // Strobe qualifiers
  logic take_slot; // Slot accepted for decode
  logic counted; // Slot claimed and recorded

  // Field lookup lives in its own module so the table stays in one place
  sdd_slot_decode u_fields (
    .slot(slot_word),
    .op(cmb_op),
    .size(cmb_size),
    .count(cmb_count),
    .sub_sel(cmb_sub_sel),
    .claimed(cmb_claimed),
    .illegal(cmb_illegal)
  );

  // Slots from other major opcodes pass through as not ours
  assign take_slot = slot_valid && enable_q;
  assign counted = take_slot && cmb_claimed; // RULE1

  // Saturating increment, shared by both statistics counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction : sat_inc

  // Next values of the result pipeline
  always_comb begin
    valid_d = 1'b0;
    op_d = op_q;
    size_d = size_q;
    count_d = count_q;
    sub_sel_d = sub_sel_q;
    illegal_d = 1'b0;
    pred_d = pred_q;
    dst_d = dst_q;
    src2_d = src2_q;
    src3_d = src3_q;
    if (counted) begin
      // Only claimed slots reach the execution side
      valid_d = 1'b1;
      op_d = cmb_op; // RULE6 RULE7 RULE8 RULE9 RULE10
      size_d = cmb_size;
      count_d = cmb_count;
      sub_sel_d = cmb_sub_sel;
      illegal_d = cmb_illegal; // RULE11
      pred_d = slot_word[sdd_pkg::PRED_HI:sdd_pkg::PRED_LO];
      dst_d = slot_word[sdd_pkg::R1_HI:sdd_pkg::R1_LO];
      src2_d = slot_word[sdd_pkg::R2_HI:sdd_pkg::R2_LO];
      src3_d = slot_word[sdd_pkg::R3_HI:sdd_pkg::R3_LO];
    end
  end

  // Result pipeline registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      valid_q <= 1'b0;
      op_q <= sdd_pkg::OP_NONE;
      size_q <= sdd_pkg::SZ_NONE;
      count_q <= 5'h00;
      sub_sel_q <= 1'b0;
      illegal_q <= 1'b0;
      pred_q <= 6'h00;
      dst_q <= 7'h00;
      src2_q <= 7'h00;
      src3_q <= 7'h00;
    end else begin
      valid_q <= valid_d;
      op_q <= op_d;
      size_q <= size_d;
      count_q <= count_d;
      sub_sel_q <= sub_sel_d;
      illegal_q <= illegal_d;
      pred_q <= pred_d;
      dst_q <= dst_d;
      src2_q <= src2_d;
      src3_q <= src3_d;
    end
  end

  // Next values of the software-visible state
  always_comb begin
    enable_d = enable_q;
    ill_cnt_d = ill_cnt_q;
    dec_cnt_d = dec_cnt_q;
    last_op_d = last_op_q;
    // Writes come first so a same-cycle event below is counted on top of a clear
    if (bus_wr) begin
      case (bus_addr)
        sdd_pkg::ADDR_CTRL: enable_d = bus_wdata[sdd_pkg::CTRL_EN_BIT];
        sdd_pkg::ADDR_ILL_CNT: ill_cnt_d = '0; // Any write clears
        sdd_pkg::ADDR_DEC_CNT: dec_cnt_d = '0; // Any write clears
        default: enable_d = enable_q; // Status and unmapped writes ignored
      endcase
    end
    if (counted) begin
      last_op_d = cmb_op;
      // Counting from the cleared value keeps an event coinciding with a clear
      dec_cnt_d = sat_inc(dec_cnt_d);
      if (cmb_illegal) begin
        ill_cnt_d = sat_inc(ill_cnt_d); // RULE11
      end
    end
  end

  // Software-visible state registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable_q <= sdd_pkg::CTRL_RESET;
      ill_cnt_q <= '0;
      dec_cnt_q <= '0;
      last_op_q <= sdd_pkg::OP_NONE;
    end else begin
      enable_q <= enable_d;
      ill_cnt_q <= ill_cnt_d;
      dec_cnt_q <= dec_cnt_d;
      last_op_q <= last_op_d;
    end
  end

  // Read data: shown only in the cycle after a read, zero otherwise
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bus_rd) begin
      case (bus_addr)
        sdd_pkg::ADDR_CTRL: rdata_d = {31'h0000_0000, enable_q};
        // Status shows the last claimed operation and whether it was illegal
        sdd_pkg::ADDR_STATUS: begin
          rdata_d = {27'h000_0000, (last_op_q == sdd_pkg::OP_ILLEGAL), last_op_q};
        end
        sdd_pkg::ADDR_ILL_CNT: rdata_d = 32'(ill_cnt_q);
        sdd_pkg::ADDR_DEC_CNT: rdata_d = 32'(dec_cnt_q);
        default: rdata_d = 32'h0000_0000; // Unmapped reads return zero
      endcase
    end
  end

  // Read data register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign bus_rdata = rdata_q;
  assign dec_valid = valid_q;
  assign dec_op = op_q;
  assign dec_size = size_q;
  assign dec_count = count_q;
  assign dec_sub_sel = sub_sel_q;
  assign dec_illegal = illegal_q;
  assign dec_guard_pred = pred_q;
  assign dec_dst_reg = dst_q;
  assign dec_src2_reg = src2_q;
  assign dec_src3_reg = src3_q;

endmodule : sdd_decoder

//--- pkg/sdd_pkg.sv
// Package for the shift/deposit operation decoder.
// Holds slot field positions, opcode values, register map and the decode result types.
// Assumes a 41-bit instruction slot and a core-clock register port with 32-bit data.
package sdd_pkg;

  // Slot geometry
  localparam int SLOT_W = 41;
  localparam int MAJ_HI = 40; // Major opcode field, top four bits
  localparam int MAJ_LO = 37;
  localparam logic [3:0] MAJ_INT_SHIFT = 4'h5; // Integer shift/test group
  localparam logic [3:0] MAJ_MM = 4'h7; // Multimedia group

  // Opcode 5 extension fields
  localparam int PAIR_HI = 35; // int_op_pair
  localparam int PAIR_LO = 34;
  localparam int SINGLE_BIT = 33; // One-bit minor opcode
  localparam int SUB13_BIT = 13; // Field pull and bit test selector
  localparam int SUB26_BIT = 26; // Field insert selector

  // Opcode 7 extension fields
  localparam int SZ_HI_BIT = 36; // size_sel_hi
  localparam int FA_HI = 35; // mm_op_field_a
  localparam int FA_LO = 34;
  localparam int SZ_LO_BIT = 33; // size_sel_lo
  localparam int OPE_BIT = 32; // op_bit_e
  localparam int FC_HI = 31; // mm_op_field_c
  localparam int FC_LO = 30;
  localparam int FB_HI = 29; // mm_op_field_b
  localparam int FB_LO = 28;
  localparam int RCNT_HI = 18; // Right-shift imm_count
  localparam int RCNT_LO = 14;
  localparam int LCNT_HI = 24; // Left-shift imm_count
  localparam int LCNT_LO = 20;

  // Operand register fields
  localparam int R3_HI = 26;
  localparam int R3_LO = 20;
  localparam int R2_HI = 19;
  localparam int R2_LO = 13;
  localparam int R1_HI = 12;
  localparam int R1_LO = 6;
  localparam int PRED_HI = 5; // guard_pred
  localparam int PRED_LO = 0;

  // Register map, byte addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_ILL_CNT = 4'h8;
  localparam logic [3:0] ADDR_DEC_CNT = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'b1;

  // Decoded operation
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_TEST_BIT = 4'b0001,
    OP_TEST_TAG = 4'b0010,
    OP_PULL_UNSIGNED = 4'b0011,
    OP_PULL_SIGNED = 4'b0100,
    OP_ZERO_INS_REG = 4'b0101,
    OP_ZERO_INS_IMM8 = 4'b0110,
    OP_PAIR_SHR = 4'b0111,
    OP_INS_IMM1 = 4'b1000,
    OP_PAR_SHR_FIXED = 4'b1001,
    OP_PAR_SHL_VAR = 4'b1010,
    OP_SHL_FULL = 4'b1011,
    OP_PAR_SHL_FIXED = 4'b1100,
    OP_ILLEGAL = 4'b1111
  } sdd_op_t;

  // Element size of a multimedia operation
  typedef enum logic [1:0] {
    SZ_NONE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10,
    SZ_FULL = 2'b11
  } sdd_size_t;

endpackage : sdd_pkg

//--- rtl/sdd_slot_decode.sv
// Combinational decode of one 41-bit slot into operation, size, count and sub-selector.
// Assumes the caller registers the result; no state lives here.
`timescale 1ns/1ps
module sdd_slot_decode (
  input wire logic [40:0] slot,
  output sdd_pkg::sdd_op_t op,
  output sdd_pkg::sdd_size_t size,
  output logic [4:0] count,
  output logic sub_sel,
  output logic claimed,
  output logic illegal
);

  logic [3:0] major; // Major opcode
  logic [1:0] pair; // int_op_pair
  logic single; // One-bit minor opcode
  logic [1:0] size_sel; // {size_sel_hi, size_sel_lo}
  logic op_bit_e;
  logic [1:0] mm_op_field_a;
  logic [1:0] mm_op_field_b;
  logic [1:0] mm_op_field_c;

  assign major = slot[sdd_pkg::MAJ_HI:sdd_pkg::MAJ_LO];
  assign pair = slot[sdd_pkg::PAIR_HI:sdd_pkg::PAIR_LO];
  assign single = slot[sdd_pkg::SINGLE_BIT];
  assign size_sel = {slot[sdd_pkg::SZ_HI_BIT], slot[sdd_pkg::SZ_LO_BIT]};
  assign op_bit_e = slot[sdd_pkg::OPE_BIT];
  assign mm_op_field_a = slot[sdd_pkg::FA_HI:sdd_pkg::FA_LO];
  assign mm_op_field_b = slot[sdd_pkg::FB_HI:sdd_pkg::FB_LO];
  assign mm_op_field_c = slot[sdd_pkg::FC_HI:sdd_pkg::FC_LO];

  // Operation lookup; anything not matched inside a claimed group falls to illegal
  always_comb begin
    op = sdd_pkg::OP_NONE;
    size = sdd_pkg::SZ_NONE;
    count = 5'h00;
    sub_sel = 1'b0;
    claimed = 1'b0;
    if (major == sdd_pkg::MAJ_INT_SHIFT) begin // RULE1
      claimed = 1'b1;
      op = sdd_pkg::OP_ILLEGAL;
      case ({pair, single}) // RULE2 RULE3
        3'b000, 3'b001: begin
          // Bit 33 is ignored here; bit 13 picks the test flavour
          sub_sel = slot[sdd_pkg::SUB13_BIT]; // RULE4
          op = sub_sel ? sdd_pkg::OP_TEST_TAG : sdd_pkg::OP_TEST_BIT; // RULE6
        end
        3'b010: begin
          sub_sel = slot[sdd_pkg::SUB13_BIT]; // RULE4
          op = sub_sel ? sdd_pkg::OP_PULL_SIGNED : sdd_pkg::OP_PULL_UNSIGNED; // RULE6
        end
        3'b011: begin
          sub_sel = slot[sdd_pkg::SUB26_BIT]; // RULE5
          op = sub_sel ? sdd_pkg::OP_ZERO_INS_IMM8 : sdd_pkg::OP_ZERO_INS_REG; // RULE7
        end
        3'b110: op = sdd_pkg::OP_PAIR_SHR; // RULE6
        3'b111: op = sdd_pkg::OP_INS_IMM1; // RULE7
        default: op = sdd_pkg::OP_ILLEGAL; // RULE11
      endcase
    end else if (major == sdd_pkg::MAJ_MM) begin
      claimed = 1'b1;
      op = sdd_pkg::OP_ILLEGAL; // RULE11
      size = sdd_pkg::sdd_size_t'(size_sel);
      if (!op_bit_e) begin
        // Fixed right: a1 b3 c0, halfword or word only
        if (mm_op_field_a == 2'h1 && mm_op_field_b == 2'h3 && mm_op_field_c == 2'h0 &&
            (size_sel == 2'b01 || size_sel == 2'b10)) begin
          op = sdd_pkg::OP_PAR_SHR_FIXED; // RULE8
          count = slot[sdd_pkg::RCNT_HI:sdd_pkg::RCNT_LO]; // RULE8
        end
        // Variable left: a0 b0 c1, three sizes
        if (mm_op_field_a == 2'h0 && mm_op_field_b == 2'h0 && mm_op_field_c == 2'h1 &&
            size_sel != 2'b00) begin
          op = (size_sel == 2'b11) ? sdd_pkg::OP_SHL_FULL : sdd_pkg::OP_PAR_SHL_VAR; // RULE9
        end
        // Fixed left: a3 b1 c1, halfword or word only
        if (mm_op_field_a == 2'h3 && mm_op_field_b == 2'h1 && mm_op_field_c == 2'h1 &&
            (size_sel == 2'b01 || size_sel == 2'b10)) begin
          op = sdd_pkg::OP_PAR_SHL_FIXED; // RULE10
          count = slot[sdd_pkg::LCNT_HI:sdd_pkg::LCNT_LO]; // RULE10
        end
      end
      // Illegal forms report no element size
      if (op == sdd_pkg::OP_ILLEGAL) begin
        size = sdd_pkg::SZ_NONE;
      end
    end
  end

  assign illegal = (op == sdd_pkg::OP_ILLEGAL); // RULE11

endmodule : sdd_slot_decode

//--- verification/sdd_exec_model.sv
// Execution-unit stand-in at the far side of the decoder.
// Assumes results arrive as one-cycle dec_valid pulses on core_clk.
`timescale 1ns/1ps
module sdd_exec_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic dec_valid,
  output int taken
);
  // Counts accepted results; it never stalls, as the decoder cannot wait
  always_ff @(posedge core_clk) begin
    if (!rstn) taken <= 0;
    else if (dec_valid) taken <= taken + 1;
  end
endmodule : sdd_exec_model

//--- verification/sdd_decoder_checker.sv
// Port-level assertions for the decoder top.
// Assumes a single core_clk domain with synchronous active-low reset.
`timescale 1ns/1ps
module sdd_decoder_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slot_valid,
  input wire logic [40:0] slot_word,
  input wire logic bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic dec_valid,
  input sdd_pkg::sdd_op_t dec_op,
  input sdd_pkg::sdd_size_t dec_size,
  input wire logic [4:0] dec_count,
  input wire logic dec_sub_sel,
  input wire logic dec_illegal
);
  logic [40:0] sw_q; // Slot seen one edge ago
  logic sv_q; // Its valid
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Keep last slot so results can be tied to their cause
  always_ff @(posedge core_clk) begin
    sw_q <= slot_word;
    sv_q <= slot_valid;
  end
  valid_cause_a: assert property (dec_valid |-> sv_q &&
    (sw_q[40:37] == 4'h5 || sw_q[40:37] == 4'h7)) else $error("result without claimed slot");
  ill_pulse_a: assert property (dec_illegal |->
    dec_valid && dec_op == sdd_pkg::OP_ILLEGAL) else $error("illegal flag stray");
  pair2_ill_a: assert property (dec_valid && sw_q[40:37] == 4'h5 &&
    sw_q[35:34] == 2'h2 |-> dec_illegal) else $error("pair 2 not illegal");
  int_size_a: assert property (dec_valid && sw_q[40:37] == 4'h5 |->
    dec_size == sdd_pkg::SZ_NONE && dec_count == 5'h00) else $error("int op with size");
  pull_sel_a: assert property (dec_valid && sw_q[40:37] == 4'h5 && sw_q[35:33] == 3'h2
    |-> dec_sub_sel == sw_q[13]) else $error("pull selector wrong");
  ins_sel_a: assert property (dec_valid && sw_q[40:37] == 4'h5 && sw_q[35:33] == 3'h3
    |-> dec_sub_sel == sw_q[26]) else $error("insert selector wrong");
  shr_count_a: assert property (dec_valid && dec_op == sdd_pkg::OP_PAR_SHR_FIXED
    |-> dec_count == sw_q[18:14]) else $error("right count wrong");
  shl_count_a: assert property (dec_valid && dec_op == sdd_pkg::OP_PAR_SHL_FIXED
    |-> dec_count == sw_q[24:20]) else $error("left count wrong");
  shl_full_a: assert property (dec_valid && dec_op == sdd_pkg::OP_SHL_FULL
    |-> dec_size == sdd_pkg::SZ_FULL && sw_q[36] && sw_q[33]) else $error("full shift wrong");
  rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule : sdd_decoder_checker
bind sdd_decoder sdd_decoder_checker i_chk (.*);

//--- verification/testbench.sv
// Self-checking bench for the decoder: reference model, register tasks, monitor.
// Assumes the package constants and a 200 MHz core_clk.
`timescale 1ns/1ps
module testbench;
  logic core_clk, rstn, slot_valid, bus_wr, bus_rd, dec_valid, dec_sub_sel, dec_illegal;
  logic [40:0] slot_word, r, ps;
  logic [3:0] bus_addr, last;
  logic [31:0] bus_wdata, bus_rdata;
  sdd_pkg::sdd_op_t dec_op;
  sdd_pkg::sdd_size_t dec_size;
  logic [4:0] dec_count;
  logic [5:0] gp;
  logic [6:0] dr, s2, s3;
  logic en_m, pv; // Modelled enable, result due
  logic [12:0] pr; // Modelled {claimed, op, size, count, sub}
  int bad_count, comparisons, n_cl, n_il, n_tot, taken;
  sdd_decoder i_dut (.core_clk(core_clk), .rstn(rstn), .slot_valid(slot_valid),
    .slot_word(slot_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .dec_valid(dec_valid), .dec_op(dec_op),
    .dec_size(dec_size), .dec_count(dec_count), .dec_sub_sel(dec_sub_sel),
    .dec_illegal(dec_illegal), .dec_guard_pred(gp), .dec_dst_reg(dr),
    .dec_src2_reg(s2), .dec_src3_reg(s3));
  sdd_exec_model i_exec (.core_clk(core_clk), .rstn(rstn), .dec_valid(dec_valid),
    .taken(taken));
  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Reference decode; unlisted opcode 5/7 combinations fall to illegal
  function automatic logic [12:0] ref_f(input logic [40:0] s);
    logic [3:0] o; // Plain code, so it may sit in a concatenation target
    logic [1:0] z;
    logic [4:0] c;
    logic b;
    logic [6:0] v;
    o = sdd_pkg::OP_ILLEGAL;
    z = {s[36], s[33]};
    c = 5'h00;
    b = 1'b0;
    v = {s[32], s[35:34], s[29:28], s[31:30]};
    if (s[40:37] == sdd_pkg::MAJ_INT_SHIFT) begin
      z = 2'h0;
      case (s[35:34])
        2'h0: {o, b} = {s[13] ? sdd_pkg::OP_TEST_TAG : sdd_pkg::OP_TEST_BIT, s[13]};
        2'h1: if (!s[33]) {o, b} = {s[13] ? sdd_pkg::OP_PULL_SIGNED : sdd_pkg::OP_PULL_UNSIGNED,
            s[13]};
          else {o, b} = {s[26] ? sdd_pkg::OP_ZERO_INS_IMM8 : sdd_pkg::OP_ZERO_INS_REG, s[26]};
        2'h3: o = s[33] ? sdd_pkg::OP_INS_IMM1 : sdd_pkg::OP_PAIR_SHR;
        default: o = sdd_pkg::OP_ILLEGAL;
      endcase
    end else if (s[40:37] != sdd_pkg::MAJ_MM) return 13'h0;
    else if (v == 7'h1c && ^z) {o, c} = {sdd_pkg::OP_PAR_SHR_FIXED, s[18:14]};
    else if (v == 7'h01 && z != 2'h0) o = &z ? sdd_pkg::OP_SHL_FULL : sdd_pkg::OP_PAR_SHL_VAR;
    else if (v == 7'h35 && ^z) {o, c} = {sdd_pkg::OP_PAR_SHL_FIXED, s[24:20]};
    else z = 2'h0;
    return {1'b1, o, z, c, b};
  endfunction : ref_f
  // Each edge: check what is due, then model the slot taken at this edge
  always @(posedge core_clk) begin
    if (rstn) begin
      chk(dec_valid, pv);
      if (pv) begin
        chk(dec_op, pr[11:8]);
        chk({dec_size, dec_count}, pr[7:1]);
        chk(dec_sub_sel, pr[0]);
        chk(dec_illegal, pr[11:8] == 4'hf);
        chk({gp, dr, s2, s3}, {ps[5:0], ps[12:6], ps[19:13], ps[26:20]});
      end
      pr = ref_f(slot_word);
      ps = slot_word;
      pv = slot_valid && en_m && pr[12];
      if (pv) begin
        n_cl++;
        n_tot++;
        n_il += (pr[11:8] == 4'hf);
        last = pr[11:8];
      end
    end
  end
  task automatic slot(input logic [40:0] s);
    @(posedge core_clk);
    slot_valid <= 1'b1;
    slot_word <= s;
  endtask : slot
  task automatic idle;
    @(posedge core_clk);
    slot_valid <= 1'b0;
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    bus_wr <= 1'b0;
    if (a == sdd_pkg::ADDR_CTRL) en_m = d[0];
    if (a == sdd_pkg::ADDR_ILL_CNT) n_il = 0;
    if (a == sdd_pkg::ADDR_DEC_CNT) n_cl = 0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    {bus_rd, bus_addr} <= {1'b1, a};
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 chk(bus_rdata, e);
  endtask : rd
  // Hang guard, well beyond the roughly 830 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end
  initial begin
    {rstn, slot_valid, slot_word, bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
    {en_m, pv, last, bad_count, comparisons, n_cl, n_il, n_tot} = '0;
    en_m = 1'b1;
    void'($urandom(32'h8c957651));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    rd(sdd_pkg::ADDR_CTRL, 32'h1);
    // Every opcode 5 selector combination, back to back
    for (int i = 0; i < 32; i++) begin
      r = 41'({$urandom(), $urandom()});
      {r[40:37], r[35:33], r[13], r[26]} = {4'h5, i[2:0], i[3], i[4]};
      slot(r);
    end
    // Every opcode 7 extension combination
    for (int i = 0; i < 512; i++) begin
      r = 41'({$urandom(), $urandom()});
      {r[40:37], r[36], r[35:34], r[33], r[32], r[31:30], r[29:28]} = {4'h7, i[8:0]};
      slot(r);
    end
    // All major opcodes, then random traffic
    for (int i = 0; i < 216; i++) begin
      r = 41'({$urandom(), $urandom()});
      if (i < 16) r[40:37] = i[3:0];
      else if (r[2]) r[40:37] = r[1] ? 4'h7 : 4'h5;
      slot(r);
    end
    idle;
    $display("test decode done");
    repeat (2) @(posedge core_clk);
    rd(sdd_pkg::ADDR_DEC_CNT, n_cl);
    rd(sdd_pkg::ADDR_ILL_CNT, n_il);
    rd(sdd_pkg::ADDR_STATUS, {27'h0, last == 4'hf, last});
    rd(4'h2, 32'h0);
    wr(sdd_pkg::ADDR_STATUS, 32'h1f);
    rd(sdd_pkg::ADDR_STATUS, {27'h0, last == 4'hf, last});
    wr(sdd_pkg::ADDR_ILL_CNT, 32'h0);
    wr(sdd_pkg::ADDR_DEC_CNT, 32'h0);
    rd(sdd_pkg::ADDR_ILL_CNT, 32'h0);
    $display("test registers done");
    // Disabled decoder drops claimed slots silently
    wr(sdd_pkg::ADDR_CTRL, 32'h0);
    rd(sdd_pkg::ADDR_CTRL, 32'h0);
    for (int i = 0; i < 20; i++) slot({4'h5, 37'(i)});
    idle;
    rd(sdd_pkg::ADDR_DEC_CNT, 32'h0);
    wr(sdd_pkg::ADDR_CTRL, 32'h1);
    rd(sdd_pkg::ADDR_CTRL, 32'h1);
    chk(taken, n_tot);
    $display("test enable done");
    print_verdict;
  end
endmodule : testbench
